// ==== ctr_regs.svh ====
// Register map, field positions, reset values and response codes for the
// compact timer run control block.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
`ifndef CTR_REGS_SVH
`define CTR_REGS_SVH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define CTR_OFS_RUN_CTRL   8'h00
`define CTR_OFS_MODE       8'h04
`define CTR_OFS_CMP_A      8'h08
`define CTR_OFS_CMP_P      8'h0c
`define CTR_OFS_COUNT      8'h10
`define CTR_OFS_STATUS     8'h14

// ----------------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------------
`define CTR_BIT_PAUSE      7
`define CTR_SEL_HI         6
`define CTR_SEL_LO         4
`define CTR_BIT_ON         3
`define CTR_RUN_CTRL_MASK  8'hf8
`define CTR_BIT_CMP_MODE   0
`define CTR_BIT_INIT_LVL   1
`define CTR_SEL_SYS_DIV4   3'h0
`define CTR_SEL_SYS        3'h1
`define CTR_SEL_HIGH_DIV16 3'h2
`define CTR_SEL_HIGH_DIV64 3'h3
`define CTR_SEL_TIMEBASE   3'h4
`define CTR_SEL_HIGH_DIV8  3'h5
`define CTR_SEL_EXT_RISE   3'h6
`define CTR_SEL_EXT_FALL   3'h7

// ----------------------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------------------
`define CTR_RST_RUN_CTRL   8'h00
`define CTR_RST_COUNT      16'h0000
`define CTR_COUNT_MAX      16'hffff
`define CTR_RESP_OKAY      2'h0
`define CTR_RESP_SLVERR    2'h2

`endif

// ==== ctr_pkg.sv ====
// Types for the compact timer run control block.
// Assumes ctr_regs.svh holds the numeric constants.
package ctr_pkg;

    // ------------------------------------------------------------------------
    // Whole state of the timer, registered once per clock
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  run_ctrl;       // Pause, clock select, on bit
        logic        cmp_mode;       // Compare match output mode
        logic        init_lvl;       // Output initial level
        logic [15:0] cmp_a;          // Full-width comparator
        logic [7:0]  cmp_p;          // High-byte comparator
        logic [15:0] count;          // Core up-counter
        logic [5:0]  presc;          // Internal clock divider
        logic        ext_s1;         // Synchroniser stage one
        logic        ext_s2;         // Synchroniser stage two
        logic        ext_s3;         // Previous synchronised level
        logic        pin;            // Timer output pin level
        logic        ovf_evt;        // Overflow event pulse
        logic        cmpa_evt;       // Comparator A event pulse
        logic        cmpp_evt;       // Comparator P event pulse
        logic        aw_got;         // Write address held
        logic        w_got;          // Write data held
        logic [7:0]  aw_addr;        // Held write address
        logic [31:0] w_data;         // Held write data
        logic [3:0]  w_strb;         // Held write strobes
        logic        bvalid;         // Write response pending
        logic [1:0]  bresp;          // Write response code
        logic        rvalid;         // Read data pending
        logic [31:0] rdata;          // Read data
        logic [1:0]  rresp;          // Read response code
    } ctr_state_type;

endpackage

// ==== ctr_timer.sv ====
// Compact timer run control: 16-bit count-up counter with pause,
// on/off, count clock selection, compare match clearing and output pin.
// Assumes one clock (aclk), synchronous active-low reset and an
// AXI4-Lite master that follows the usual valid/ready handshakes.
`timescale 1ns/1ps
`include "ctr_regs.svh"

module ctr_timer
    import ctr_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Count clock sources
    input  wire logic        timebase_clock,
    input  wire logic        ext_count_input,
    // Timer outputs
    output logic             timer_output_pin,
    output logic             overflow_event,
    output logic             match_a_event,
    output logic             match_p_event
);

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    ctr_state_type s_q;
    ctr_state_type s_d;

    // ------------------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------------------
    logic [2:0]  clk_sel;
    logic        is_on;
    logic        is_paused;
    logic        tick;
    logic        ext_rise;
    logic        ext_fall;
    logic        do_write;
    logic        wr_hit;
    logic        new_on;
    logic        turn_on;
    logic        advance;
    logic        at_max;
    logic        hit_a;
    logic        hit_p;
    logic [31:0] rd_word;
    logic        rd_hit;

    // Control field decode
    assign clk_sel   = s_q.run_ctrl[`CTR_SEL_HI:`CTR_SEL_LO];
    assign is_on     = s_q.run_ctrl[`CTR_BIT_ON];
    assign is_paused = s_q.run_ctrl[`CTR_BIT_PAUSE];

    // Edges of the synchronised external input
    assign ext_rise = s_q.ext_s2 & ~s_q.ext_s3;
    assign ext_fall = ~s_q.ext_s2 & s_q.ext_s3;

    // ------------------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------------------
    // The high-speed clock is taken as the system clock; every source but
    // timebase_clock, which is used directly as a level, becomes a one-cycle tick on aclk.
    always_comb begin
        unique case (clk_sel)
            `CTR_SEL_SYS_DIV4:   tick = (s_q.presc[1:0] == 2'h3);
            `CTR_SEL_SYS:        tick = 1'b1;
            `CTR_SEL_HIGH_DIV16: tick = (s_q.presc[3:0] == 4'hf);
            `CTR_SEL_HIGH_DIV64: tick = (s_q.presc[5:0] == 6'h3f);
            `CTR_SEL_TIMEBASE:   tick = timebase_clock;
            `CTR_SEL_HIGH_DIV8:  tick = (s_q.presc[2:0] == 3'h7);
            `CTR_SEL_EXT_RISE:   tick = ext_rise;
            `CTR_SEL_EXT_FALL:   tick = ext_fall;
        endcase
    end

    // ------------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------------
    // Overflow at all ones, A on full match, P on high byte at period end
    assign at_max = (s_q.count == `CTR_COUNT_MAX);
    assign hit_a  = (s_q.count == s_q.cmp_a);
    assign hit_p  = (s_q.count[15:8] == s_q.cmp_p) & (s_q.count[7:0] == 8'hff);

    // Counter advances only when on, not paused, and a tick arrives
    assign advance = is_on & ~is_paused & tick;

    // ------------------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------------------
    assign do_write = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
    assign wr_hit   = (s_q.aw_addr == `CTR_OFS_RUN_CTRL) & s_q.w_strb[0];
    assign new_on   = s_q.w_data[`CTR_BIT_ON];
    assign turn_on  = do_write & wr_hit & new_on & ~is_on;

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (s_axi_araddr)
            `CTR_OFS_RUN_CTRL: begin
                rd_word[7:0] = s_q.run_ctrl & `CTR_RUN_CTRL_MASK;
            end
            `CTR_OFS_MODE: begin
                rd_word[`CTR_BIT_CMP_MODE] = s_q.cmp_mode;
                rd_word[`CTR_BIT_INIT_LVL] = s_q.init_lvl;
            end
            `CTR_OFS_CMP_A: begin
                rd_word[15:0] = s_q.cmp_a;
            end
            `CTR_OFS_CMP_P: begin
                rd_word[7:0] = s_q.cmp_p;
            end
            `CTR_OFS_COUNT: begin
                rd_word[15:0] = s_q.count;
            end
            `CTR_OFS_STATUS: begin
                rd_word[0] = s_q.pin;
                rd_word[1] = s_q.ext_s2;
                rd_word[2] = is_on & ~is_paused;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // External input synchroniser, stage one feeds only stage two
        s_d.ext_s1 = ext_count_input;
        s_d.ext_s2 = s_q.ext_s1;
        s_d.ext_s3 = s_q.ext_s2;

        // Divider runs only while the timer is on, saving power when off
        if (is_on) begin
            s_d.presc = s_q.presc + 6'h01;
        end else begin
            s_d.presc = 6'h00;
        end

        // Events are one-cycle pulses
        s_d.ovf_evt  = 1'b0;
        s_d.cmpa_evt = 1'b0;
        s_d.cmpp_evt = 1'b0;

        // Counting; pause and off both just hold the value
        if (advance) begin
            if (at_max | hit_a | hit_p) begin
                s_d.count = `CTR_RST_COUNT;
            end else begin
                s_d.count = s_q.count + 16'h0001;
            end
            s_d.ovf_evt  = at_max;
            s_d.cmpa_evt = hit_a;
            s_d.cmpp_evt = hit_p;
            if (hit_a & s_q.cmp_mode) begin
                s_d.pin = ~s_q.pin;
            end
        end

        // Write address channel
        if (s_axi_awvalid & s_axi_awready) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end

        // Write data channel
        if (s_axi_wvalid & s_axi_wready) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end

        // Register update once both halves are held
        if (do_write) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = `CTR_RESP_OKAY;
            unique case (s_q.aw_addr)
                `CTR_OFS_RUN_CTRL: begin
                    if (s_q.w_strb[0]) begin
                        // Low bits stored as zero
                        s_d.run_ctrl = s_q.w_data[7:0] & `CTR_RUN_CTRL_MASK;
                    end
                end
                `CTR_OFS_MODE: begin
                    if (s_q.w_strb[0]) begin
                        s_d.cmp_mode = s_q.w_data[`CTR_BIT_CMP_MODE];
                        s_d.init_lvl = s_q.w_data[`CTR_BIT_INIT_LVL];
                    end
                end
                `CTR_OFS_CMP_A: begin
                    if (s_q.w_strb[0]) begin
                        s_d.cmp_a[7:0] = s_q.w_data[7:0];
                    end
                    if (s_q.w_strb[1]) begin
                        s_d.cmp_a[15:8] = s_q.w_data[15:8];
                    end
                end
                `CTR_OFS_CMP_P: begin
                    if (s_q.w_strb[0]) begin
                        s_d.cmp_p = s_q.w_data[7:0];
                    end
                end
                `CTR_OFS_COUNT,
                `CTR_OFS_STATUS: begin
                    // Read-only, write ignored
                end
                default: begin
                    s_d.bresp = `CTR_RESP_SLVERR;
                end
            endcase
        end

        // Switching on clears the counter and, in compare output mode, restores the pin
        if (turn_on) begin
            s_d.count = `CTR_RST_COUNT;
            s_d.presc = 6'h00;
            if (s_q.cmp_mode) begin
                s_d.pin = s_q.init_lvl;
            end
        end

        // Write response retires on handshake
        if (s_q.bvalid & s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Read: take address, answer next cycle
        if (s_q.rvalid & s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid & s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_word;
            s_d.rresp  = rd_hit ? `CTR_RESP_OKAY : `CTR_RESP_SLVERR;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q          <= '0;
            s_q.run_ctrl <= `CTR_RST_RUN_CTRL;
            s_q.count    <= `CTR_RST_COUNT;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Handshake readies are combinational on held state
    assign s_axi_awready = ~s_q.aw_got & ~s_q.bvalid;
    assign s_axi_wready  = ~s_q.w_got & ~s_q.bvalid;
    assign s_axi_arready = ~s_q.rvalid;

    // Responses and data straight from flip-flops
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    // Timer pin and event pulses
    assign timer_output_pin = s_q.pin;
    assign overflow_event   = s_q.ovf_evt;
    assign match_a_event    = s_q.cmpa_evt;
    assign match_p_event    = s_q.cmpp_evt;

endmodule

// ==== ctr_timer_monitor.sv ====
// Checker for ctr_timer: bus handshakes, run control and output pin.
// Assumes it is bound onto ctr_timer and sees only that module's ports.
`timescale 1ns/1ps
`include "ctr_regs.svh"

module ctr_timer_monitor (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Timer outputs
    input wire logic        timer_output_pin,
    input wire logic        overflow_event,
    input wire logic        match_p_event
);
    logic [7:0]  wa_q;
    logic [31:0] wd_q;
    logic        on_q, pause_q, mode_q, lvl_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------
    // Shadow of the written run control and mode bits
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_q    <= 1'b0;
            pause_q <= 1'b0;
            mode_q  <= 1'b0;
            lvl_q   <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
            if ($rose(s_axi_bvalid) && wa_q == `CTR_OFS_RUN_CTRL) begin
                on_q    <= wd_q[`CTR_BIT_ON];
                pause_q <= wd_q[`CTR_BIT_PAUSE];
            end
            if ($rose(s_axi_bvalid) && wa_q == `CTR_OFS_MODE) begin
                mode_q <= wd_q[`CTR_BIT_CMP_MODE];
                lvl_q  <= wd_q[`CTR_BIT_INIT_LVL];
            end
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_idle3;
        (!on_q || pause_q)[*3];
    endsequence
    sequence s_turn_on;
        $rose(s_axi_bvalid) && wa_q == `CTR_OFS_RUN_CTRL && wd_q[`CTR_BIT_ON] && !on_q && mode_q;
    endsequence
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    property p_rd_lat;
        s_rd |=> s_axi_rvalid;
    endproperty
    property p_wr_lat;
        s_wr |-> ##2 s_axi_bvalid;
    endproperty
    property p_ctrl_low;
        s_rd ##0 (s_axi_araddr == `CTR_OFS_RUN_CTRL) |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[2:0] == 3'h0;
    endproperty
    property p_idle;
        s_idle3 |-> !(overflow_event || match_p_event);
    endproperty
    property p_pin_init;
        s_turn_on |-> ##[0:1] (timer_output_pin == lvl_q);
    endproperty
    property p_evt_pulse;
        (overflow_event || match_p_event) |=> !(overflow_event || match_p_event);
    endproperty

    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    a_r_hold: assert property (p_r_hold) else $error("read data changed before taken");
    a_ar_block: assert property (p_ar_block) else $error("read address ready while data pending");
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    a_ctrl_low: assert property (p_ctrl_low) else $error("control low bits not zero");
    a_idle: assert property (p_idle) else $error("event while stopped");
    a_pin_init: assert property (p_pin_init) else $error("pin not at initial level");
    a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than a cycle");
endmodule

bind ctr_timer ctr_timer_monitor u_mon (.*);

// ==== ctr_timer_tb_top.sv ====
// Testbench for ctr_timer: register access, run control and counting.
// Assumes the register map of ctr_regs.svh and a 125 MHz aclk.
`timescale 1ns/1ps
`include "ctr_regs.svh"

module ctr_timer_tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        timebase_clock, ext_count_input, timer_output_pin;
    logic        overflow_event, match_a_event, match_p_event;
    int          m_cnt, m_cmpa, m_cmpp, m_on, m_pause, m_sel, m_mode, m_lvl, m_pin;
    int          m_ma, m_mp, n_ma, n_mp, n_ov, k, err_total, total_checks;
    int          sels[5] = '{0, 1, 2, 3, 5};
    int          divs[5] = '{4, 1, 16, 64, 8};

    ctr_timer uut (.*);

    // Clock and event counting
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        if (match_a_event === 1'b1) n_ma++;
        if (match_p_event === 1'b1) n_mp++;
        if (overflow_event === 1'b1) n_ov++;
    end

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 64) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n = 0;
        int th = $urandom % 5;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= v;
        s_axi_wstrb   <= 4'hf;
        while (n < 64 && (n == 0 || s_axi_awvalid || s_axi_wvalid || !(s_axi_bvalid && s_axi_bready))) begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= n > th && !(s_axi_bvalid && s_axi_bready);
        end
        rs = s_axi_bresp;
        tmo(n);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n = 0;
        int th = $urandom % 4;
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        while (n < 64 && (n == 0 || s_axi_arvalid || !(s_axi_rvalid && s_axi_rready))) begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= n > th && !(s_axi_rvalid && s_axi_rready);
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
        tmo(n);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, d, r);
        chk(d, e);
    endtask

    // ------------------------------------------------------------------
    // Model of the run control and counter
    // ------------------------------------------------------------------
    task automatic wctl(input logic [7:0] v);
        wr(`CTR_OFS_RUN_CTRL, {24'h0, v}, r);
        if (v[`CTR_BIT_ON] && !m_on) m_cnt = 0;
        if (v[`CTR_BIT_ON] && !m_on && m_mode) m_pin = m_lvl;
        m_on = v[`CTR_BIT_ON];
        m_pause = v[`CTR_BIT_PAUSE];
        m_sel = v[`CTR_SEL_HI:`CTR_SEL_LO];
    endtask
    task automatic m_tick();
        bit ha, hp;
        if (m_on && !m_pause) begin
            ha = m_cnt == m_cmpa;
            hp = (m_cnt >> 8) == m_cmpp && (m_cnt & 255) == 255;
            m_ma += ha;
            m_mp += hp;
            if (ha && m_mode) m_pin = !m_pin;
            m_cnt = (ha || hp || m_cnt == 65535) ? 0 : m_cnt + 1;
        end
    endtask
    // n timebase ticks and n full pulses on the external input
    task automatic stim(input int n);
        repeat (n) begin
            @(posedge aclk);
            timebase_clock <= 1'b1;
            ext_count_input <= 1'b1;
            if (m_sel == 4 || m_sel == 6) m_tick();
            @(posedge aclk);
            timebase_clock <= 1'b0;
            repeat (3) @(posedge aclk);
            ext_count_input <= 1'b0;
            if (m_sel == 7) m_tick();
            repeat (3) @(posedge aclk);
        end
        repeat (4) @(posedge aclk);
    endtask

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {timebase_clock, ext_count_input} = '0;
        void'($urandom(72));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`CTR_OFS_RUN_CTRL, 0);
        rc(`CTR_OFS_COUNT, 0);
        rd(8'h40, d, r);
        chk(r, `CTR_RESP_SLVERR);
        wr(8'h40, 1, r);
        chk(r, `CTR_RESP_SLVERR);
        $display("Reset test done");
        wr(`CTR_OFS_CMP_A, 32'hffff, r);
        m_cmpa = 65535;
        wr(`CTR_OFS_CMP_P, 32'hff, r);
        m_cmpp = 255;
        for (int s = 0; s < 8; s++) begin
            k = $urandom;
            wctl(8'(8'h80 | s << 4 | k[2:0]));
            rc(`CTR_OFS_RUN_CTRL, 8'(8'h80 | s << 4));
        end
        foreach (divs[i]) begin
            wctl(8'(sels[i] << 4));
            wctl(8'(sels[i] << 4 | 8));
            repeat (256) @(posedge aclk);
            rd(`CTR_OFS_COUNT, d, r);
            chk(d >= 256 / divs[i] && d <= 280 / divs[i] + 1, 1);
        end
        $display("Select test done");
        wctl(8'h40);
        wctl(8'h48);
        stim(5 + $urandom % 20);
        rc(`CTR_OFS_COUNT, m_cnt);
        wctl(8'hc8);
        stim(5);
        rc(`CTR_OFS_COUNT, m_cnt);
        wctl(8'h48);
        stim(3);
        rc(`CTR_OFS_COUNT, m_cnt);
        wctl(8'h40);
        stim(4);
        rc(`CTR_OFS_COUNT, m_cnt);
        wctl(8'h48);
        rc(`CTR_OFS_COUNT, 0);
        $display("Run control test done");
        for (int s = 6; s < 8; s++) begin
            wctl(8'(s << 4));
            wctl(8'(s << 4 | 8));
            stim(3 + $urandom % 6);
            rc(`CTR_OFS_COUNT, m_cnt);
        end
        $display("External input test done");
        wr(`CTR_OFS_CMP_A, 3, r);
        m_cmpa = 3;
        m_mode = 1;
        for (int i = 0; i < 2; i++) begin
            wr(`CTR_OFS_MODE, i ? 1 : 3, r);
            m_lvl = !i;
            wctl(8'h40);
            wctl(8'h48);
            repeat (2) @(posedge aclk);
            chk(timer_output_pin, m_pin);
            stim(6);
            chk(timer_output_pin, m_pin);
            rc(`CTR_OFS_COUNT, m_cnt);
        end
        chk(n_ma, m_ma);
        wr(`CTR_OFS_CMP_A, 32'hffff, r);
        m_cmpa = 65535;
        wr(`CTR_OFS_CMP_P, 0, r);
        m_cmpp = 0;
        wctl(8'h40);
        wctl(8'h48);
        stim(258);
        rc(`CTR_OFS_COUNT, m_cnt);
        chk(n_mp, m_mp);
        // Full wrap at system clock rate gives exactly one overflow
        wr(`CTR_OFS_CMP_P, 32'hff, r);
        wctl(8'h10);
        wctl(8'h18);
        repeat (65600) @(posedge aclk);
        chk(n_ov, 1);
        wctl(8'h10);
        $display("Compare test done");
        give_verdict();
    end
endmodule
